// ---- pkg/eti_pkg.sv ----
// Function
// - Rise-enable bits 15..11 arm overflow, audio_saturation_flag, minus-X, plus-X, ready rising edges
// - Rise-enable bits 9..0 arm rising edges of the matching general pins
// - Fall-enable bits 15..11 arm falling edges of the same five sources
// - Fall-enable bits 9..0 arm falling edges of the matching general pins
// - Status read gives latched overflow, audio_saturation_flag, minus-X, plus-X, ready at 15..11
// - Writing one to status bits 15..11 clears them; zero leaves them
// - Status bits 9..0 hold per-pin flags, each cleared by writing one
// - Enable, status and panel control registers are all zero after reset
// - Panel bit 13 reads minus-X pin level: zero pen down, one pen up
// - Panel bit 12 reads plus-X pin level: zero pen down, one pen up
// - Panel bit 11 turns the panel bias circuit on
// - Panel bit 10 turns hysteresis off on the pen-sense inputs
// - Mode bits 9:8: 00 interrupt, 01 pressure, 1x position measurement
// - Panel bits 7..4 ground plus-Y, minus-Y, plus-X, minus-X
// - Panel bits 3..0 power plus-Y, minus-Y, plus-X, minus-X
package eti_pkg;

    localparam logic [6:0]  RISE_EN_IDX   = 7'h5e;
    localparam logic [6:0]  FALL_EN_IDX   = 7'h60;
    localparam logic [6:0]  STATUS_IDX    = 7'h62;
    localparam logic [6:0]  PANEL_IDX     = 7'h64;

    localparam int          NUM_SRC       = 15;
    localparam int          NUM_PIN       = 10;
    localparam int          NUM_SYNC      = 12;

    localparam logic [15:0] EN_RST        = 16'h0000;
    localparam logic [15:0] STATUS_RST    = 16'h0000;
    localparam logic [11:0] PANEL_RST     = 12'h000;

    localparam int          RSVD_BIT      = 10;
    localparam int          MX_LEVEL_BIT  = 13;
    localparam int          PX_LEVEL_BIT  = 12;
    localparam int          BIAS_BIT      = 11;
    localparam int          HYST_OFF_BIT  = 10;
    localparam int          MODE_HI_BIT   = 9;
    localparam int          MODE_LO_BIT   = 8;
    localparam int          PY_GND_BIT    = 7;
    localparam int          MY_GND_BIT    = 6;
    localparam int          PX_GND_BIT    = 5;
    localparam int          MX_GND_BIT    = 4;
    localparam int          PY_DRV_BIT    = 3;
    localparam int          MY_DRV_BIT    = 2;
    localparam int          PX_DRV_BIT    = 1;
    localparam int          MX_DRV_BIT    = 0;

    typedef enum logic [1:0] {
        ETI_MODE_IRQ      = 2'b00,
        ETI_MODE_PRESSURE = 2'b01,
        ETI_MODE_POS_A    = 2'b10,
        ETI_MODE_POS_B    = 2'b11
    } eti_mode_t;

    // Register image to packed source vector, bit 10 dropped
    function automatic logic [14:0] reg_to_src(input logic [15:0] r);
        reg_to_src = {r[15:11], r[9:0]};
    endfunction : reg_to_src

    // Source vector to register image, bit 10 zero
    function automatic logic [15:0] src_to_reg(input logic [14:0] s);
        src_to_reg = {s[14:10], 1'b0, s[9:0]};
    endfunction : src_to_reg

endpackage : eti_pkg

// ---- rtl/eti_pin_sync.sv ----
module eti_pin_sync
    import eti_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] stable
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } eti_sync_state_t;

    eti_sync_state_t st;
    eti_sync_state_t next_st;

    always_comb
    begin
        next_st    = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // Accept a level only once stages two and three agree
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.level[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign stable = st.level;

endmodule : eti_pin_sync

// ---- rtl/eti_edge_flags.sv ----
module eti_edge_flags
    import eti_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] level,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    input  wire logic [W-1:0] clear,
    output logic      [W-1:0] flags,
    output logic              any_flag
);

    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] flag;
        logic         any;
    } eti_edge_state_t;

    eti_edge_state_t st;
    eti_edge_state_t next_st;
    logic [W-1:0]    set;

    always_comb
    begin
        next_st      = st;
        next_st.prev = level;
        set = (level & ~st.prev & rise_en) |
              (~level & st.prev & fall_en);
        // Set wins over a clear in the same cycle
        next_st.flag = (st.flag & ~clear) | set;
        next_st.any  = |next_st.flag;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign flags    = st.flag;
    assign any_flag = st.any;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    w1c_clear_a: assert property (
        ((clear & ~set) != '0) |=> (($past(clear & ~set) & flags) == '0))
        else $error("flag survived a write-one clear");

    set_wins_a: assert property (
        ((set & clear) != '0) |=> (($past(set & clear) & ~flags) == '0))
        else $error("clear beat a same-cycle edge");

endmodule : eti_edge_flags

// ---- rtl/eti_irq_panel.sv ----
module eti_irq_panel
    import eti_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        adc_overrange_flag,
    input  wire logic        audio_saturation_flag,
    input  wire logic        conv_ready,
    input  wire logic        panel_minus_x_pin,
    input  wire logic        panel_plus_x_pin,
    input  wire logic [9:0]  io_pin,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    input  wire logic [6:0]  reg_index,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_rdone,
    output logic             irq,
    output logic             bias_en,
    output logic             schmitt_hyst_off,
    output logic      [1:0]  panel_op_mode,
    output logic             interrupt_mode,
    output logic             pressure_mode,
    output logic             position_mode,
    output logic             plus_y_ground,
    output logic             minus_y_ground,
    output logic             plus_x_ground,
    output logic             minus_x_ground,
    output logic             plus_y_drive,
    output logic             minus_y_drive,
    output logic             plus_x_drive,
    output logic             minus_x_drive
);

    typedef struct packed {
        logic [14:0] rise_en;
        logic [14:0] fall_en;
        logic [11:0] panel;
        logic        intr;
        logic        pressure;
        logic        position;
        logic [15:0] rdata;
        logic        rdone;
    } eti_top_state_t;

    localparam eti_top_state_t ST_RST = '{
        rise_en:  reg_to_src(EN_RST),
        fall_en:  reg_to_src(EN_RST),
        panel:    PANEL_RST,
        intr:     1'b1,
        pressure: 1'b0,
        position: 1'b0,
        rdata:    16'h0000,
        rdone:    1'b0
    };

    eti_top_state_t st;
    eti_top_state_t next_st;

    logic [11:0]    sync_stable;
    logic           mx_level;
    logic           px_level;
    logic [14:0]    src_level;
    logic [14:0]    flags;
    logic [14:0]    clear;
    logic           any_flag;
    eti_mode_t      next_mode;

    // Pin inputs pass the three-stage agreement filter
    eti_pin_sync #(
        .W (NUM_SYNC)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .raw     ({panel_minus_x_pin, panel_plus_x_pin, io_pin}),
        .stable  (sync_stable)
    );

    assign mx_level = sync_stable[11];
    assign px_level = sync_stable[10];

    // Internal flags arrive on this clock and need no filter
    assign src_level = {adc_overrange_flag,
                        audio_saturation_flag,
                        mx_level,
                        px_level,
                        conv_ready,
                        sync_stable[9:0]};

    eti_edge_flags #(
        .W (NUM_SRC)
    ) u_flags (
        .clk      (clk),
        .reset_n  (reset_n),
        .level    (src_level),
        .rise_en  (st.rise_en),
        .fall_en  (st.fall_en),
        .clear    (clear),
        .flags    (flags),
        .any_flag (any_flag)
    );

    // Register writes, status clears and read answers
    always_comb
    begin
        next_st       = st;
        next_st.rdone = 1'b0;
        clear         = '0;
        if (reg_write)
        begin
            case (reg_index)
                RISE_EN_IDX:
                begin
                    next_st.rise_en = reg_to_src(reg_wdata);
                end
                FALL_EN_IDX:
                begin
                    next_st.fall_en = reg_to_src(reg_wdata);
                end
                STATUS_IDX:
                begin
                    clear = reg_to_src(reg_wdata);
                end
                PANEL_IDX:
                begin
                    next_st.panel = reg_wdata[11:0];
                end
                default:
                begin
                end
            endcase
        end
        if (reg_read)
        begin
            next_st.rdone = 1'b1;
            case (reg_index)
                RISE_EN_IDX:
                begin
                    next_st.rdata = src_to_reg(st.rise_en);
                end
                FALL_EN_IDX:
                begin
                    next_st.rdata = src_to_reg(st.fall_en);
                end
                STATUS_IDX:
                begin
                    next_st.rdata = src_to_reg(flags);
                end
                PANEL_IDX:
                begin
                    next_st.rdata = {2'b00, mx_level, px_level,
                                     st.panel};
                end
                default:
                begin
                    next_st.rdata = 16'h0000;
                end
            endcase
        end
        next_mode = eti_mode_t'(next_st.panel[MODE_HI_BIT:MODE_LO_BIT]);
        unique case (next_mode)
            ETI_MODE_IRQ:
            begin
                next_st.intr     = 1'b1;
                next_st.pressure = 1'b0;
                next_st.position = 1'b0;
            end
            ETI_MODE_PRESSURE:
            begin
                next_st.intr     = 1'b0;
                next_st.pressure = 1'b1;
                next_st.position = 1'b0;
            end
            ETI_MODE_POS_A,
            ETI_MODE_POS_B:
            begin
                next_st.intr     = 1'b0;
                next_st.pressure = 1'b0;
                next_st.position = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= ST_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata        = st.rdata;
    assign reg_rdone        = st.rdone;
    assign irq              = any_flag;
    assign bias_en          = st.panel[BIAS_BIT];
    assign schmitt_hyst_off = st.panel[HYST_OFF_BIT];
    assign panel_op_mode    = st.panel[MODE_HI_BIT:MODE_LO_BIT];
    assign interrupt_mode   = st.intr;
    assign pressure_mode    = st.pressure;
    assign position_mode    = st.position;
    assign plus_y_ground    = st.panel[PY_GND_BIT];
    assign minus_y_ground   = st.panel[MY_GND_BIT];
    assign plus_x_ground    = st.panel[PX_GND_BIT];
    assign minus_x_ground   = st.panel[MX_GND_BIT];
    assign plus_y_drive     = st.panel[PY_DRV_BIT];
    assign minus_y_drive    = st.panel[MY_DRV_BIT];
    assign plus_x_drive     = st.panel[PX_DRV_BIT];
    assign minus_x_drive    = st.panel[MX_DRV_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Steps of writes and reads of the enable, status and panel registers
    sequence wr_rise_s;
        reg_write && !reg_read && reg_index == RISE_EN_IDX;
    endsequence

    sequence wr_fall_s;
        reg_write && !reg_read && reg_index == FALL_EN_IDX;
    endsequence

    sequence rd_rise_s;
        reg_read && !reg_write && reg_index == RISE_EN_IDX;
    endsequence

    sequence rd_fall_s;
        reg_read && !reg_write && reg_index == FALL_EN_IDX;
    endsequence

    sequence rd_enable_s;
        reg_read && (reg_index == RISE_EN_IDX ||
                     reg_index == FALL_EN_IDX ||
                     reg_index == STATUS_IDX);
    endsequence

    sequence rd_panel_s;
        reg_read && reg_index == PANEL_IDX;
    endsequence

    sequence wr_panel_s;
        reg_write && reg_index == PANEL_IDX;
    endsequence

    rise_en_echo_a: assert property (
        wr_rise_s ##1 rd_rise_s |=>
        reg_rdone && reg_rdata == ($past(reg_wdata, 2) & 16'hfbff))
        else $error("rise enable did not read back");

    fall_en_echo_a: assert property (
        wr_fall_s ##1 rd_fall_s |=>
        reg_rdone && reg_rdata == ($past(reg_wdata, 2) & 16'hfbff))
        else $error("fall enable did not read back");

    reserved_zero_a: assert property (
        rd_enable_s |=> reg_rdone && !reg_rdata[RSVD_BIT])
        else $error("reserved bit read as one");

    rise_sets_flag_a: assert property (
        1'b1 |-> (($past(src_level) & ~$past(src_level, 2) &
                  $past(st.rise_en) & ~flags) == '0))
        else $error("enabled rising edge not flagged");

    fall_sets_flag_a: assert property (
        1'b1 |-> ((~$past(src_level) & $past(src_level, 2) &
                  $past(st.fall_en) & ~flags) == '0))
        else $error("enabled falling edge not flagged");

    read_answer_a: assert property (
        reg_read |=> reg_rdone)
        else $error("read strobe got no answer");

    answer_pulse_a: assert property (
        !reg_read |=> !reg_rdone)
        else $error("read answer without a strobe");

    flag_sticky_a: assert property (
        1'b1 |-> (($past(flags) & ~$past(clear) & ~flags) == '0))
        else $error("flag dropped without a clear");

    status_read_a: assert property (
        reg_read && reg_index == STATUS_IDX |=>
        reg_rdata == src_to_reg($past(flags)))
        else $error("status read differs from flags");

    pen_level_a: assert property (
        rd_panel_s |=>
        reg_rdata[MX_LEVEL_BIT:PX_LEVEL_BIT] ==
        $past({mx_level, px_level}))
        else $error("pen level bits wrong");

    irq_tracks_a: assert property (
        irq == (flags != '0))
        else $error("irq does not match flags");

    panel_drive_a: assert property (
        wr_panel_s |=>
        {plus_y_ground, minus_y_ground, plus_x_ground,
         minus_x_ground, plus_y_drive, minus_y_drive,
         plus_x_drive, minus_x_drive, bias_en,
         schmitt_hyst_off} ==
        {$past(reg_wdata[7:0]), $past(reg_wdata[11]),
         $past(reg_wdata[10])})
        else $error("panel drive bits not applied");

    mode_decode_a: assert property (
        position_mode == panel_op_mode[1] &&
        pressure_mode == (panel_op_mode == 2'b01) &&
        interrupt_mode == (panel_op_mode == 2'b00))
        else $error("panel mode decode wrong");

endmodule : eti_irq_panel

// ---- tb/eti_host_model.sv ----
module eti_host_model
(
    input  wire logic        clk,
    output logic             reg_write,
    output logic             reg_read,
    output logic      [6:0]  reg_index,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rdone
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_index = 7'h00;
        reg_wdata = 16'h0000;
    end

    // One write slot; released lines show the inverse of the last value
    task automatic wr(input logic [6:0] idx, input logic [15:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_index = idx;
        reg_wdata = d;
        @(posedge clk);
        @(negedge clk);
        reg_write = 1'b0;
        reg_index = ~idx;
        reg_wdata = ~d;
    endtask : wr

    // Optional write slot, then a read slot in the very next cycle
    task automatic rd(input logic [6:0] idx, input logic wr,
                      input logic [15:0] wd, output logic [15:0] d,
                      output logic ok);
        @(negedge clk);
        reg_write = wr;
        reg_index = idx;
        if (wr)
        begin
            reg_wdata = wd;
            @(posedge clk);
            @(negedge clk);
            reg_write = 1'b0;
        end
        reg_read  = 1'b1;
        @(posedge clk);
        // Answer stands only for the cycle after the read edge
        @(negedge clk);
        reg_read  = 1'b0;
        reg_index = ~idx;
        ok = (reg_rdone === 1'b1);
        d  = reg_rdata;
    endtask : rd
endmodule : eti_host_model

// ---- tb/eti_irq_panel_tb.sv ----
module eti_irq_panel_tb
    import eti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [6:0]  idx;
        logic [15:0] wd;
        logic [15:0] rd;
    } eti_row_t;

    logic        clk;
    logic        reset_n;
    logic        adc_overrange_flag;
    logic        audio_saturation_flag;
    logic        conv_ready;
    logic        panel_minus_x_pin;
    logic        panel_plus_x_pin;
    logic [9:0]  io_pin;
    logic        reg_write;
    logic        reg_read;
    logic [6:0]  reg_index;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rdone;
    logic        irq;
    logic        bias_en;
    logic        schmitt_hyst_off;
    logic [1:0]  panel_op_mode;
    logic        interrupt_mode;
    logic        pressure_mode;
    logic        position_mode;
    logic        plus_y_ground;
    logic        minus_y_ground;
    logic        plus_x_ground;
    logic        minus_x_ground;
    logic        plus_y_drive;
    logic        minus_y_drive;
    logic        plus_x_drive;
    logic        minus_x_drive;
    int          miscompares;
    int          comparisons;
    int          cycles;
    logic [15:0] m;
    logic [15:0] pan;

    eti_row_t rows [11] = '{
        '{RISE_EN_IDX, 16'hffff, 16'hfbff}, '{RISE_EN_IDX, 16'h0400, 16'h0000},
        '{FALL_EN_IDX, 16'hffff, 16'hfbff}, '{FALL_EN_IDX, 16'h0400, 16'h0000},
        '{PANEL_IDX, 16'hffff, 16'h0fff}, '{PANEL_IDX, 16'h0d5a, 16'h0d5a},
        '{PANEL_IDX, 16'h06a5, 16'h06a5}, '{PANEL_IDX, 16'h0100, 16'h0100},
        '{PANEL_IDX, 16'h0000, 16'h0000}, '{7'h70, 16'hffff, 16'h0000},
        '{STATUS_IDX, 16'hffff, 16'h0000}
    };

    eti_host_model host (
        .clk       (clk),
        .reg_write (reg_write),
        .reg_read  (reg_read),
        .reg_index (reg_index),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .reg_rdone (reg_rdone)
    );

    eti_irq_panel dut (
        .clk(clk), .reset_n(reset_n),
        .adc_overrange_flag(adc_overrange_flag),
        .audio_saturation_flag(audio_saturation_flag),
        .conv_ready(conv_ready), .panel_minus_x_pin(panel_minus_x_pin),
        .panel_plus_x_pin(panel_plus_x_pin), .io_pin(io_pin),
        .reg_write(reg_write), .reg_read(reg_read), .reg_index(reg_index),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdone(reg_rdone),
        .irq(irq), .bias_en(bias_en), .schmitt_hyst_off(schmitt_hyst_off),
        .panel_op_mode(panel_op_mode), .interrupt_mode(interrupt_mode),
        .pressure_mode(pressure_mode), .position_mode(position_mode),
        .plus_y_ground(plus_y_ground), .minus_y_ground(minus_y_ground),
        .plus_x_ground(plus_x_ground), .minus_x_ground(minus_x_ground),
        .plus_y_drive(plus_y_drive), .minus_y_drive(minus_y_drive),
        .plus_x_drive(plus_x_drive), .minus_x_drive(minus_x_drive)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [6:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd(idx, 1'b0, 16'h0000, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask : rdchk

    // Write, then read back in the very next cycle
    task automatic wrchk(input logic [6:0] idx, input logic [15:0] wd,
                         input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd(idx, 1'b1, wd, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask : wrchk

    // Drives sources by status bit position, then lets the filters settle
    task automatic set_src(input logic [15:0] v);
        @(negedge clk);
        adc_overrange_flag    = v[15];
        audio_saturation_flag = v[14];
        panel_minus_x_pin     = v[13];
        panel_plus_x_pin      = v[12];
        conv_ready            = v[11];
        io_pin                = v[9:0];
        repeat (6) @(negedge clk);
    endtask : set_src

    task automatic reset_check();
        @(negedge clk);
        reset_n = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        chk({11'h000, irq, interrupt_mode, pressure_mode, position_mode,
             bias_en}, 16'h0008);
        rdchk(RISE_EN_IDX, 16'h0000);
        rdchk(FALL_EN_IDX, 16'h0000);
        rdchk(STATUS_IDX, 16'h0000);
        rdchk(PANEL_IDX, 16'h0000);
    endtask : reset_check

    initial
    begin
        reset_n = 1'b0;
        {adc_overrange_flag, audio_saturation_flag, conv_ready} = 3'h0;
        {panel_minus_x_pin, panel_plus_x_pin} = 2'h0;
        io_pin = 10'h000;
        reset_check();
        foreach (rows[i])
        begin
            wrchk(rows[i].idx, rows[i].wd, rows[i].rd);
            if (rows[i].idx == PANEL_IDX)
            begin
                pan = {4'h0, bias_en, schmitt_hyst_off, panel_op_mode,
                       plus_y_ground, minus_y_ground, plus_x_ground,
                       minus_x_ground, plus_y_drive, minus_y_drive,
                       plus_x_drive, minus_x_drive};
                chk(pan, rows[i].rd);
                chk({13'h0000, interrupt_mode, pressure_mode, position_mode},
                    {13'h0000, rows[i].wd[9:8] == 2'b00,
                     rows[i].wd[9:8] == 2'b01, rows[i].wd[9]});
            end
        end
        for (int b = 0; b < 16; b++)
        begin
            if (b != 10)
            begin
                m = 16'h0001 << b;
                set_src(16'h0000);
                host.wr(FALL_EN_IDX, 16'h0000);
                host.wr(RISE_EN_IDX, 16'hffff);
                host.wr(STATUS_IDX, 16'hffff);
                set_src(m);
                rdchk(STATUS_IDX, m);
                host.wr(RISE_EN_IDX, 16'h0000);
                host.wr(FALL_EN_IDX, 16'hffff);
                host.wr(STATUS_IDX, 16'hffff);
                set_src(16'hffff);
                set_src(~m);
                rdchk(STATUS_IDX, m);
            end
        end
        host.wr(FALL_EN_IDX, 16'h0000);
        host.wr(RISE_EN_IDX, 16'hffff);
        host.wr(STATUS_IDX, 16'hffff);
        set_src(16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        set_src(16'hffff);
        rdchk(STATUS_IDX, 16'hfbff);
        chk({15'h0000, irq}, 16'h0001);
        rdchk(PANEL_IDX, 16'h3000);
        host.wr(STATUS_IDX, 16'h8401);
        rdchk(STATUS_IDX, 16'h7bfe);
        host.wr(STATUS_IDX, 16'h0000);
        rdchk(STATUS_IDX, 16'h7bfe);
        host.wr(STATUS_IDX, 16'h7bfe);
        rdchk(STATUS_IDX, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        host.wr(RISE_EN_IDX, 16'h0000);
        host.wr(FALL_EN_IDX, 16'h0000);
        set_src(16'h0000);
        rdchk(STATUS_IDX, 16'h0000);
        rdchk(PANEL_IDX, 16'h0000);
        host.wr(RISE_EN_IDX, 16'hffff);
        // Edge and write-one clear land on the same clock edge
        fork
            host.wr(STATUS_IDX, 16'h0800);
            set_src(16'h0800);
        join
        rdchk(STATUS_IDX, 16'h0800);
        host.wr(PANEL_IDX, 16'h0fff);
        set_src(16'hffff);
        set_src(16'h0000);
        reset_check();
        finish_test();
    end
endmodule : eti_irq_panel_tb
